// file: src/tec_timer.sv
// Module: 16-bit timer/event counter with reload, buffered byte access and divider output
//
// Notes on behaviour
// - Converter select 0 joins counter and reload bytes into one 16-bit timer.
// - Reload low write fills a buffer; high write loads both bytes at once.
// - Reading counter high latches counter low; low read returns that latch.
// - Mode field picks clock: sys, quarter, rtc, ad clock, event, pulse width.
// - Edge select 0 counts rising edges, 1 counts falling edges.
// - Run enable 0 stops counting, 1 lets the counter advance.
// - Control bits 0 to 2 always read as zero.
// - Counting resumes from the value already in the counter.
// - Passing FFFF reloads from reload register and sets overflow flag together.
// - Pulse width: start on active edge, stop on return, clear run enable.
// - Pulse width measures once, keeps result, is edge triggered.
// - Overflow while measuring reloads and raises the request as usual.
// - Overflow wakes from halt and may toggle the divider pin.
// - Clearing overflow interrupt enable stops the request in every mode.
// - Divider option: pin latch 0 enables divider, 1 holds pin low.
// - Reload write while stopped also loads the counter; running, only reload.
// - Running count undisturbed by reload writes until next overflow.
// - Reading counter high blocks the count for that cycle.
`timescale 1ns/10ps

module tec_timer
  import tec_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  input  wire logic       clkEn,
  input  wire logic [7:0] memAddr,
  input  wire logic       memWrEn,
  input  wire logic       memRdEn,
  input  wire logic [7:0] memWrData,
  output logic      [7:0] memRdData,
  input  wire logic       eventInputPin,
  input  wire logic       adClockPin,
  input  wire logic       rtcTick,
  input  wire logic       overflowIrqEnable,
  input  wire logic       overflowFlagClear,
  input  wire logic       dividerOption,
  input  wire logic       dividerPinLatch,
  output logic            overflowFlag,
  output logic            irqRequest,
  output logic            wakeUp,
  output logic            dividerPin
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic activeEdge(input logic prev, input logic cur, input logic fall);
    activeEdge = fall ? (prev & ~cur) : (~prev & cur);
  endfunction : activeEdge

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr == ofs);
  endfunction : hit

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    PW_WAIT,
    PW_COUNT,
    PW_DONE
  } tec_pw_e;

  logic [15:0] count_q;
  logic [15:0] reload_q;
  logic [7:0]  reloadLowBuf_q;
  logic [7:0]  countLowWrBuf_q;
  logic [7:0]  countLowRdBuf_q;
  logic        edgeSel_q;
  logic        runEn_q;
  tec_mode_e   mode_q;
  logic [7:0]  convSetup_q;
  logic [7:0]  rdData_q;
  logic        ovfFlag_q;
  logic        irq_q;
  logic        wake_q;
  logic        divToggle_q;
  logic        divPin_q;
  logic [1:0]  quarterCnt_q;
  tec_pw_e     pwState_q;

  logic        evSync1_q;
  logic        evSync2_q;
  logic        evPrev_q;
  logic        adSync1_q;
  logic        adSync2_q;
  logic        adPrev_q;

  logic        wrCountHigh;
  logic        wrCountLow;
  logic        wrControl;
  logic        wrReloadHigh;
  logic        wrReloadLow;
  logic        wrConvSetup;
  logic        rdCountHigh;
  logic        timerSel;
  logic        quarterTick;
  logic        evActive;
  logic        evReturn;
  logic        adRise;
  logic        srcTick;
  logic        countStep;
  logic        overflow;
  logic        pwEnd;
  logic [15:0] reloadNext;

  // ---------------------------------------------------------------
  // Access decode
  // ---------------------------------------------------------------
  assign wrCountHigh  = memWrEn & hit(memAddr, OFS_COUNT_HIGH);
  assign wrCountLow   = memWrEn & hit(memAddr, OFS_COUNT_LOW);
  assign wrControl    = memWrEn & hit(memAddr, OFS_CONTROL);
  assign wrReloadHigh = memWrEn & hit(memAddr, OFS_RELOAD_HIGH);
  assign wrReloadLow  = memWrEn & hit(memAddr, OFS_RELOAD_LOW);
  assign wrConvSetup  = memWrEn & hit(memAddr, OFS_CONV_SETUP);
  assign rdCountHigh  = memRdEn & hit(memAddr, OFS_COUNT_HIGH);

  assign reloadNext = {memWrData, reloadLowBuf_q};

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  // Pins are asynchronous; edges compare the second stage with its delayed copy
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      evSync1_q <= 1'b0;
      evSync2_q <= 1'b0;
      evPrev_q  <= 1'b0;
      adSync1_q <= 1'b0;
      adSync2_q <= 1'b0;
      adPrev_q  <= 1'b0;
    end else if (clkEn) begin
      evSync1_q <= eventInputPin;
      evSync2_q <= evSync1_q;
      evPrev_q  <= evSync2_q;
      adSync1_q <= adClockPin;
      adSync2_q <= adSync1_q;
      adPrev_q  <= adSync2_q;
    end
  end

  assign evActive = activeEdge(evPrev_q, evSync2_q, edgeSel_q);
  assign evReturn = activeEdge(evPrev_q, evSync2_q, ~edgeSel_q);
  assign adRise   = activeEdge(adPrev_q, adSync2_q, 1'b0);

  // ---------------------------------------------------------------
  // Quarter system clock prescaler
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      quarterCnt_q <= 2'b00;
    end else if (clkEn) begin
      quarterCnt_q <= quarterCnt_q + 2'b01;
    end
  end

  assign quarterTick = (quarterCnt_q == QUARTER_LAST);

  // ---------------------------------------------------------------
  // Count source selection
  // ---------------------------------------------------------------
  assign timerSel = ~convSetup_q[CONV_SELECT_BIT];

  always_comb begin
    case (mode_q)
      MODE_SYS_CLK:  srcTick = 1'b1;
      MODE_QUARTER:  srcTick = quarterTick;
      MODE_RTC:      srcTick = rtcTick;
      MODE_AD_CLOCK: srcTick = adRise;
      MODE_EVENT:    srcTick = evActive;
      MODE_PULSE_W:  srcTick = quarterTick & (pwState_q == PW_COUNT);
      default:       srcTick = 1'b0;
    endcase
  end

  // Reading the high byte freezes the count; a tick may be lost
  assign countStep = timerSel & runEn_q & srcTick & ~rdCountHigh;
  assign overflow  = countStep & (count_q == COUNT_MAX);

  // ---------------------------------------------------------------
  // Pulse width measurement
  // ---------------------------------------------------------------
  assign pwEnd = (mode_q == MODE_PULSE_W) & (pwState_q == PW_COUNT) & evReturn;

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      pwState_q <= PW_WAIT;
    end else if (clkEn) begin
      if (!runEn_q || mode_q != MODE_PULSE_W || !timerSel) begin
        pwState_q <= PW_WAIT;
      end else begin
        case (pwState_q)
          PW_WAIT: begin
            if (evActive) begin
              pwState_q <= PW_COUNT;
            end
          end
          PW_COUNT: begin
            if (evReturn) begin
              pwState_q <= PW_DONE;
            end
          end
          PW_DONE:  pwState_q <= PW_DONE;
          default:  pwState_q <= PW_WAIT;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Control and converter setup registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      edgeSel_q <= RST_CONTROL[CTL_EDGE_BIT];
      runEn_q   <= RST_CONTROL[CTL_RUN_BIT];
      mode_q    <= tec_mode_e'(RST_CONTROL[CTL_MODE_MSB:CTL_MODE_LSB]);
    end else if (clkEn) begin
      if (wrControl) begin
        edgeSel_q <= memWrData[CTL_EDGE_BIT];
        runEn_q   <= memWrData[CTL_RUN_BIT];
        mode_q    <= tec_mode_e'(memWrData[CTL_MODE_MSB:CTL_MODE_LSB]);
      end else if (pwEnd) begin
        runEn_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      convSetup_q <= RST_CONV_SETUP;
    end else if (clkEn && wrConvSetup) begin
      convSetup_q <= memWrData & CONV_SETUP_MASK;
    end
  end

  // ---------------------------------------------------------------
  // Reload register and its low byte buffer
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      reloadLowBuf_q <= RST_COUNT[7:0];
      reload_q       <= RST_COUNT;
    end else if (clkEn) begin
      if (wrReloadLow) begin
        reloadLowBuf_q <= memWrData;
      end
      if (wrReloadHigh) begin
        reload_q <= reloadNext;
      end
    end
  end

  // ---------------------------------------------------------------
  // Counter
  // ---------------------------------------------------------------
  // Power-up contents are undefined in the part; cleared here for determinism
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      countLowWrBuf_q <= RST_COUNT[7:0];
      count_q         <= RST_COUNT;
    end else if (clkEn) begin
      if (wrCountLow) begin
        countLowWrBuf_q <= memWrData;
      end
      if (wrCountHigh) begin
        count_q <= {memWrData, countLowWrBuf_q};
      end else if (wrReloadHigh && !runEn_q) begin
        count_q <= reloadNext;
      end else if (overflow) begin
        count_q <= reload_q;
      end else if (countStep) begin
        count_q <= count_q + 16'h0001;
      end
    end
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      countLowRdBuf_q <= RST_COUNT[7:0];
      rdData_q        <= 8'h00;
    end else if (clkEn) begin
      if (rdCountHigh) begin
        countLowRdBuf_q <= count_q[7:0];
      end
      if (!memRdEn) begin
        rdData_q <= 8'h00;
      end else begin
        case (memAddr)
          OFS_COUNT_HIGH:  rdData_q <= count_q[15:8];
          OFS_COUNT_LOW:   rdData_q <= countLowRdBuf_q;
          OFS_CONTROL:     rdData_q <= {mode_q, runEn_q, edgeSel_q, 3'b000};
          OFS_RELOAD_HIGH: rdData_q <= reload_q[15:8];
          OFS_RELOAD_LOW:  rdData_q <= reload_q[7:0];
          OFS_CONV_SETUP:  rdData_q <= convSetup_q;
          default:         rdData_q <= 8'h00;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Overflow flag, request and wake-up
  // ---------------------------------------------------------------
  // A new overflow wins over a clear in the same cycle
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      ovfFlag_q <= 1'b0;
    end else if (clkEn) begin
      if (overflow) begin
        ovfFlag_q <= 1'b1;
      end else if (overflowFlagClear) begin
        ovfFlag_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      irq_q  <= 1'b0;
      wake_q <= 1'b0;
    end else if (clkEn) begin
      irq_q  <= (ovfFlag_q | overflow) & overflowIrqEnable;
      wake_q <= overflow;
    end
  end

  // ---------------------------------------------------------------
  // Frequency divider output
  // ---------------------------------------------------------------
  // Without the option the pin simply follows its port latch
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      divToggle_q <= 1'b0;
      divPin_q    <= 1'b0;
    end else if (clkEn) begin
      if (overflow) begin
        divToggle_q <= ~divToggle_q;
      end
      if (!dividerOption) begin
        divPin_q <= dividerPinLatch;
      end else if (dividerPinLatch) begin
        divPin_q <= 1'b0;
      end else begin
        divPin_q <= divToggle_q ^ overflow;
      end
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign memRdData    = rdData_q;
  assign overflowFlag = ovfFlag_q;
  assign irqRequest   = irq_q;
  assign wakeUp       = wake_q;
  assign dividerPin   = divPin_q;

endmodule : tec_timer

// file: common/tec_pkg.sv
// Package: register map, field layout, reset values and modes of the 16-bit timer/event counter
package tec_pkg;

  // ---------------------------------------------------------------
  // Register offsets in data memory
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_COUNT_HIGH  = 8'h20;
  localparam logic [7:0] OFS_COUNT_LOW   = 8'h21;
  localparam logic [7:0] OFS_CONTROL     = 8'h22;
  localparam logic [7:0] OFS_RELOAD_HIGH = 8'h23;
  localparam logic [7:0] OFS_RELOAD_LOW  = 8'h24;
  localparam logic [7:0] OFS_CONV_SETUP  = 8'h25;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CTL_EDGE_BIT    = 3;
  localparam int CTL_RUN_BIT     = 4;
  localparam int CTL_MODE_LSB    = 5;
  localparam int CTL_MODE_MSB    = 7;
  localparam int CONV_SELECT_BIT = 1;

  // Converter setup bits that store a value; bits 2 and 3 read zero
  localparam logic [7:0] CONV_SETUP_MASK = 8'hF3;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0]  RST_CONTROL    = 8'h08;
  localparam logic [7:0]  RST_CONV_SETUP = 8'h80;
  localparam logic [15:0] RST_COUNT      = 16'h0000;
  localparam logic [15:0] COUNT_MAX      = 16'hFFFF;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int         QUARTER_DIV  = 4;
  localparam logic [1:0] QUARTER_LAST = 2'(QUARTER_DIV - 1);

  // ---------------------------------------------------------------
  // Clock source modes
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_SYS_CLK   = 3'h0,
    MODE_QUARTER   = 3'h1,
    MODE_RTC       = 3'h2,
    MODE_AD_CLOCK  = 3'h3,
    MODE_EVENT     = 3'h4,
    MODE_PULSE_W   = 3'h5,
    MODE_UNUSED6   = 3'h6,
    MODE_UNUSED7   = 3'h7
  } tec_mode_e;

endpackage : tec_pkg

// file: verification/tec_pulse_src.sv
// Partner model: external pulse source for the event and A/D clock pins
`timescale 1ns/10ps

module tec_pulse_src (
  input  wire logic       ref_clk,
  input  wire logic       startReq,
  input  wire logic [4:0] lowLen,
  input  wire logic [4:0] highLen,
  input  wire logic [1:0] pulseCnt,
  output logic            pinOut
);
  // Idle low between bursts, edges land right after a clock edge
  initial begin
    pinOut = 1'b0;
    forever begin
      @(posedge ref_clk);
      if (startReq) begin
        repeat (pulseCnt) begin
          repeat (lowLen) @(posedge ref_clk);
          pinOut <= 1'b1;
          repeat (highLen) @(posedge ref_clk);
          pinOut <= 1'b0;
        end
      end
    end
  end
endmodule : tec_pulse_src

// file: verification/tec_timer_properties.sv
// Checker: concurrent properties on the timer's ports
`timescale 1ns/10ps

module tec_timer_properties
  import tec_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       nrst,
  input wire logic       clkEn,
  input wire logic [7:0] memAddr,
  input wire logic       memWrEn,
  input wire logic       memRdEn,
  input wire logic [7:0] memWrData,
  input wire logic [7:0] memRdData,
  input wire logic       eventInputPin,
  input wire logic       adClockPin,
  input wire logic       rtcTick,
  input wire logic       overflowIrqEnable,
  input wire logic       overflowFlagClear,
  input wire logic       dividerOption,
  input wire logic       dividerPinLatch,
  input wire logic       overflowFlag,
  input wire logic       irqRequest,
  input wire logic       wakeUp,
  input wire logic       dividerPin
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  chk_ctl_low_zero: assert property (memRdEn && clkEn && memAddr == OFS_CONTROL |=> memRdData[2:0] == 3'h0)
    else $error("control low bits not zero");
  chk_conv_rsvd_zero: assert property (memRdEn && clkEn && memAddr == OFS_CONV_SETUP |=> memRdData[3:2] == 2'h0)
    else $error("converter setup spare bits not zero");
  chk_rd_unmapped: assert property (memRdEn && clkEn && memAddr > OFS_CONV_SETUP |=> memRdData == 8'h00)
    else $error("unmapped read not zero");
  chk_rd_idle: assert property (!memRdEn && clkEn |=> memRdData == 8'h00)
    else $error("read data without read");
  chk_flag_sticky: assert property (overflowFlag && !overflowFlagClear && clkEn |=> overflowFlag)
    else $error("overflow flag dropped");
  chk_irq_raise: assert property (overflowFlag && overflowIrqEnable && clkEn |=> irqRequest)
    else $error("request missing");
  chk_irq_enable: assert property (irqRequest && $past(clkEn) |-> $past(overflowIrqEnable))
    else $error("request while disabled");
  chk_wake_cause: assert property (wakeUp |-> overflowFlag)
    else $error("wake without overflow");
  chk_div_masked: assert property (dividerOption && dividerPinLatch && clkEn |=> !dividerPin)
    else $error("masked divider pin not low");
  chk_div_plain: assert property (!dividerOption && clkEn |=> dividerPin == $past(dividerPinLatch))
    else $error("pin not following latch");
  chk_div_toggle: assert property ($changed(dividerPin) && $past(dividerOption) && $past(dividerOption, 2)
    && !$past(dividerPinLatch) && !$past(dividerPinLatch, 2) |-> wakeUp)
    else $error("divider toggled without overflow");

  cover property (overflowFlag && overflowIrqEnable ##1 irqRequest);
  cover property ($rose(wakeUp));
  cover property ($changed(dividerPin) && dividerOption);
endmodule : tec_timer_properties

bind tec_timer tec_timer_properties u_props (
  .ref_clk(ref_clk), .nrst(nrst), .clkEn(clkEn), .memAddr(memAddr), .memWrEn(memWrEn),
  .memRdEn(memRdEn), .memWrData(memWrData), .memRdData(memRdData), .eventInputPin(eventInputPin),
  .adClockPin(adClockPin), .rtcTick(rtcTick), .overflowIrqEnable(overflowIrqEnable),
  .overflowFlagClear(overflowFlagClear), .dividerOption(dividerOption), .dividerPinLatch(dividerPinLatch),
  .overflowFlag(overflowFlag), .irqRequest(irqRequest), .wakeUp(wakeUp), .dividerPin(dividerPin)
);

// file: verification/testbench.sv
// Testbench: register access, counting modes, pulse width and divider pin
`timescale 1ns/10ps

module testbench;
  import tec_pkg::*;
  logic        ref_clk, nrst, memWrEn, memRdEn, eventInputPin, adClockPin, rtcTick, startEv;
  logic [7:0]  memAddr, memWrData, memRdData, rdv;
  logic        overflowIrqEnable, overflowFlagClear, dividerOption, dividerPinLatch;
  logic        overflowFlag, irqRequest, wakeUp, dividerPin;
  logic [4:0]  evLow, evHigh, adLow, adHigh;
  logic [1:0]  evCnt, ed;
  logic [15:0] rld, st, v, v2;
  logic [2:0]  md;
  int          error_cnt, checked, cycles, tk, wraps, wakes;
  int          ticks [8] = '{40, 10, 5, 3, 3, 0, 0, 0};

  tec_timer u_dut (.ref_clk(ref_clk), .nrst(nrst), .clkEn(1'b1), .memAddr(memAddr), .memWrEn(memWrEn),
    .memRdEn(memRdEn), .memWrData(memWrData), .memRdData(memRdData), .eventInputPin(eventInputPin),
    .adClockPin(adClockPin), .rtcTick(rtcTick), .overflowIrqEnable(overflowIrqEnable),
    .overflowFlagClear(overflowFlagClear), .dividerOption(dividerOption), .dividerPinLatch(dividerPinLatch),
    .overflowFlag(overflowFlag), .irqRequest(irqRequest), .wakeUp(wakeUp), .dividerPin(dividerPin));
  tec_pulse_src u_ev (.ref_clk(ref_clk), .startReq(startEv), .lowLen(evLow), .highLen(evHigh),
    .pulseCnt(evCnt), .pinOut(eventInputPin));
  tec_pulse_src u_ad (.ref_clk(ref_clk), .startReq(startEv), .lowLen(adLow), .highLen(adHigh),
    .pulseCnt(2'h3), .pinOut(adClockPin));

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // ---------------------------------------------------------------
  // Bus cycles, model and compares
  // ---------------------------------------------------------------
  // Two cycles per access so a strobe is never lowered and raised in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    memAddr = a; memWrData = d; memWrEn = 1'b1;
    @(negedge ref_clk); memWrEn = 1'b0; @(negedge ref_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    memAddr = a; memRdEn = 1'b1;
    @(negedge ref_clk); memRdEn = 1'b0; d = memRdData; @(negedge ref_clk);
  endtask : rd
  task automatic rd_cnt(output logic [15:0] c);
    rd(OFS_COUNT_HIGH, c[15:8]); rd(OFS_COUNT_LOW, c[7:0]);
  endtask : rd_cnt
  task automatic ld_cnt(input logic [15:0] c);
    wr(OFS_COUNT_LOW, c[7:0]); wr(OFS_COUNT_HIGH, c[15:8]);
  endtask : ld_cnt
  task automatic fire();
    startEv = 1'b1; @(negedge ref_clk); startEv = 1'b0;
  endtask : fire
  task automatic clr_flag();
    overflowFlagClear = 1'b1; @(negedge ref_clk); overflowFlagClear = 1'b0; @(negedge ref_clk);
  endtask : clr_flag
  task automatic chk16(input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk16
  task automatic chk8(input logic [7:0] e, input logic [7:0] g);
    chk16({8'h00, e}, {8'h00, g});
  endtask : chk8
  task automatic chkf(input logic e, input logic g);
    chk16({15'h0000, e}, {15'h0000, g});
  endtask : chkf
  function automatic logic [15:0] adv(input logic [15:0] c, input int t);
    for (int k = 0; k < t; k++) begin
      if (c == COUNT_MAX) wraps++;
      c = (c == COUNT_MAX) ? rld : c + 16'h0001;
    end
    return c;
  endfunction : adv

  task automatic test_done();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : test_done

  // One-cycle wake pulse, counted where it is settled
  always @(negedge ref_clk) if (wakeUp === 1'b1) wakes++;

  // Whole run is a few hundred cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      $display("ERROR t=%0t timeout", $time);
      test_done();
    end
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    {nrst, memWrEn, memRdEn, rtcTick, startEv, overflowFlagClear, dividerOption, dividerPinLatch} = '0;
    {memAddr, memWrData, evLow, evHigh, adLow, adHigh} = '0;
    overflowIrqEnable = 1'b1; evCnt = 2'h3;
    void'($urandom(32'h8fa4));
    repeat (6) @(negedge ref_clk);
    nrst = 1'b1;
    rd(OFS_CONTROL, rdv); chk8(RST_CONTROL, rdv);
    rd(OFS_CONV_SETUP, rdv); chk8(RST_CONV_SETUP, rdv);
    rd(8'h26, rdv); chk8(8'h00, rdv);
    wr(OFS_CONV_SETUP, 8'hFF); rd(OFS_CONV_SETUP, rdv); chk8(CONV_SETUP_MASK, rdv);
    wr(OFS_CONV_SETUP, RST_CONV_SETUP);
    rld = 16'($urandom);
    wr(OFS_RELOAD_LOW, rld[7:0]); rd(OFS_RELOAD_LOW, rdv); chk8(8'h00, rdv);
    wr(OFS_RELOAD_HIGH, rld[15:8]); rd(OFS_RELOAD_LOW, rdv); chk8(rld[7:0], rdv);
    rd_cnt(v); chk16(rld, v);
    $display("test registers done");
    dividerOption = 1'b1;
    ld_cnt(16'hFFF0); st = 16'($urandom);
    wr(OFS_CONTROL, 8'h10); wr(OFS_RELOAD_LOW, st[7:0]); wr(OFS_RELOAD_HIGH, st[15:8]);
    repeat (14) @(negedge ref_clk);
    wr(OFS_CONTROL, 8'h00); rld = st;
    rd_cnt(v); chk16(adv(16'hFFF0, 20), v);
    chk16(16'(wraps), 16'(wakes));
    chkf(wraps[0], dividerPin);
    chkf(1'b1, overflowFlag);
    chkf(1'b1, irqRequest);
    clr_flag(); chkf(1'b0, overflowFlag);
    chkf(1'b0, irqRequest);
    // Count high read stalls the count for its cycle
    st = v;
    wr(OFS_CONTROL, 8'h10); rd_cnt(v); wr(OFS_CONTROL, 8'h00);
    chk16(adv(st, 1), v);
    rd_cnt(v); chk16(adv(st, 5), v);
    $display("test reload and read done");
    for (int i = 0; i < 9; i++) begin
      md = (i == 8) ? MODE_SYS_CLK : 3'(i);
      if (md == MODE_PULSE_W) continue;
      if (i == 8) wr(OFS_CONV_SETUP, 8'h82);
      ed = 2'($urandom % 2); overflowIrqEnable = 1'($urandom);
      {evLow, evHigh, adLow, adHigh} = {5'($urandom % 5 + 1), 5'($urandom % 5 + 1), 5'($urandom % 5 + 1), 5'(3)};
      st = 16'($urandom); ld_cnt(st);
      wr(OFS_CONTROL, {md, 1'b1, ed[0], 3'h0});
      fork
        fire();
        repeat (5) begin
          repeat (3) @(negedge ref_clk);
          rtcTick = 1'b1; @(negedge ref_clk); rtcTick = 1'b0;
        end
        repeat (38) @(negedge ref_clk);
      join
      wr(OFS_CONTROL, {md, 1'b0, ed[0], 3'h0});
      tk = (i == 8) ? 0 : ticks[md];
      rd_cnt(v); chk16(adv(st, tk), v);
      clr_flag();
      if (i == 8) wr(OFS_CONV_SETUP, RST_CONV_SETUP);
      $display("test mode %0d done", i);
    end
    ld_cnt(16'h0000); evCnt = 2'h1; evLow = 5'h02; evHigh = 5'($urandom % 16 + 8);
    wr(OFS_CONTROL, 8'hB0); fire(); repeat (40) @(negedge ref_clk);
    rd(OFS_CONTROL, rdv); chk8(8'hA0, rdv);
    rd_cnt(v); chkf(1'b1, (v >= evHigh / 4 - 1) && (v <= evHigh / 4 + 1));
    fire(); repeat (40) @(negedge ref_clk);
    rd_cnt(v2); chk16(v, v2);
    $display("test pulse width done");
    dividerPinLatch = 1'b1; repeat (2) @(negedge ref_clk);
    chkf(1'b0, dividerPin);
    $display("test divider done");
    test_done();
  end
endmodule : testbench
